// ===== verilog/acx_pkg.sv
// Summary of operation
// RULE1: Clear accumulator zeroes all eight bits in one cycle, flags unchanged.
// RULE2: Clear bit zeroes carry or an addressed bit in one cycle, no other flags.
// RULE3: Complement accumulator inverts every bit in one cycle, flags unchanged.
// RULE4: Complement bit inverts carry or an addressed bit in one cycle.
// RULE5: Port read-modify-write takes the old value from the output latch, not pins.
// RULE6: Decimal adjust adds six to low nibble if above nine or aux carry set.
// RULE7: Then adds six to high nibble if carry or above nine; carry only set.
// RULE8: Whole decimal adjust completes in one single-cycle instruction.
// RULE9: Decrement subtracts one with wrap, no flags, one cycle in every form.
// RULE10: Divide is unsigned, quotient to A, remainder to B, clears carry and overflow, four cycles.
// RULE11: Divide by zero sets overflow and clears carry; results undefined.
// RULE12: Decrement-branch decrements with wrap, branches on nonzero, no flags.
// RULE13: Branch target is advanced program counter plus sign-extended displacement.
// RULE14: Decrement-branch operand is a working register or a direct byte only.
// RULE15: Compare-branch sets carry when first below second, branches on inequality, pc plus three.
// RULE16: Decrement-branch takes two machine cycles.
package acx_pkg;

  typedef enum logic [3:0] {
    OP_NONE      = 4'h0,
    OP_CLR_ACC   = 4'h1,
    OP_CLR_BIT   = 4'h2,
    OP_INV_ACC   = 4'h3,
    OP_INV_BIT   = 4'h4,
    OP_DA        = 4'h5,
    OP_DEC       = 4'h6,
    OP_DIV       = 4'h7,
    OP_DECREMENT_BRANCH_NONZERO_OP      = 4'h8,
    OP_COMPARE_BRANCH_UNEQUAL_OP      = 4'h9
  } acx_op_e;

  // Operand location for byte and bit operations
  typedef enum logic [2:0] {
    LOC_ACC      = 3'h0,
    LOC_WREG     = 3'h1,
    LOC_DIRECT   = 3'h2,
    LOC_INDIRECT = 3'h3,
    LOC_CARRY    = 3'h4,
    LOC_PORT     = 3'h5
  } acx_loc_e;

  // Request from the decoder
  typedef struct packed {
    acx_op_e     op;
    acx_loc_e    loc;
    logic [7:0]  operand;
    logic [7:0]  compare;
    logic [7:0]  rel;
    logic [15:0] pc_next;
    logic [2:0]  bit_sel;
  } acx_req_s;

  // Result to write-back
  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  breg;
    logic [7:0]  data;
    logic        data_we;
    acx_loc_e    loc;
    logic        cy;
    logic        ov;
    logic        cy_we;
    logic        ov_we;
    logic        branch;
    logic [15:0] target;
  } acx_res_s;

  localparam logic [3:0] CYC_ONE   = 4'h1;
  localparam logic [3:0] CYC_DECREMENT_BRANCH_NONZERO_OP  = 4'h2;
  localparam logic [3:0] CYC_COMPARE_BRANCH_UNEQUAL_OP  = 4'h2;
  localparam logic [3:0] CYC_DIV   = 4'h4;
  localparam logic [3:0] BCD_MAX   = 4'h9;
  localparam logic [3:0] BCD_FIX   = 4'h6;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE  = 8'h01;

endpackage : acx_pkg

// ===== verilog/acx_alu.sv
`timescale 1ns/1ps
module acx_alu (
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  // Request
  input  wire logic              i_start,
  input  wire acx_pkg::acx_req_s i_req,
  input  wire logic [7:0]        i_acc,
  input  wire logic [7:0]        i_breg,
  input  wire logic              i_cy,
  input  wire logic              i_ac,
  input  wire logic [7:0]        i_port_latch,
  // Result
  output logic                   o_busy,
  output logic                   o_done,
  output acx_pkg::acx_res_s      o_res
);

  //////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [7:0] dec8(input logic [7:0] v);
    dec8 = v - acx_pkg::BYTE_ONE;
  endfunction : dec8

  function automatic logic [15:0] rel_tgt(input logic [15:0] pc, input logic [7:0] r);
    rel_tgt = pc + {{8{r[7]}}, r};
  endfunction : rel_tgt

  //////////////////////////////////////////////////////////////////////////
  // Datapath

  acx_pkg::acx_req_s req_q;
  logic [3:0]        cnt_q;
  logic              busy_q;
  logic [7:0]        old_v;
  acx_pkg::acx_res_s res_d;
  acx_pkg::acx_res_s res_q;
  logic              done_q;
  logic [8:0]        da_lo;
  logic [8:0]        da_hi;
  logic              da_cy;

  // Old operand value; port writes read the output latch, never the pins
  always_comb begin
    if (i_req.loc == acx_pkg::LOC_PORT) begin
      old_v = i_port_latch; // RULE5
    end else if (i_req.loc == acx_pkg::LOC_ACC) begin
      old_v = i_acc;
    end else begin
      old_v = i_req.operand;
    end
  end

  // Decimal adjust, both steps combinational within one cycle
  always_comb begin
    if (i_acc[3:0] > acx_pkg::BCD_MAX || i_ac) begin
      da_lo = {1'b0, i_acc} + {5'h00, acx_pkg::BCD_FIX}; // RULE6
    end else begin
      da_lo = {1'b0, i_acc};
    end
    da_cy = i_cy | da_lo[8]; // RULE6
    if (da_lo[7:4] > acx_pkg::BCD_MAX || da_cy) begin
      da_hi = {1'b0, da_lo[7:0]} + {1'b0, acx_pkg::BCD_FIX, 4'h0}; // RULE7
    end else begin
      da_hi = {1'b0, da_lo[7:0]};
    end
  end

  // Result computation at issue, captured in one register
  always_comb begin
    res_d        = '0;
    res_d.acc    = i_acc;
    res_d.breg   = i_breg;
    res_d.loc    = i_req.loc;
    res_d.cy     = i_cy;
    res_d.target = i_req.pc_next;
    case (i_req.op)
      acx_pkg::OP_CLR_ACC: begin
        res_d.acc = acx_pkg::BYTE_ZERO; // RULE1
      end
      acx_pkg::OP_CLR_BIT: begin
        if (i_req.loc == acx_pkg::LOC_CARRY) begin
          res_d.cy    = 1'b0; // RULE2
          res_d.cy_we = 1'b1;
        end else begin
          res_d.data    = old_v & ~(acx_pkg::BYTE_ONE << i_req.bit_sel); // RULE2
          res_d.data_we = 1'b1;
        end
      end
      acx_pkg::OP_INV_ACC: begin
        res_d.acc = ~i_acc; // RULE3
      end
      acx_pkg::OP_INV_BIT: begin
        if (i_req.loc == acx_pkg::LOC_CARRY) begin
          res_d.cy    = ~i_cy; // RULE4
          res_d.cy_we = 1'b1;
        end else begin
          res_d.data    = old_v ^ (acx_pkg::BYTE_ONE << i_req.bit_sel); // RULE4
          res_d.data_we = 1'b1;
        end
      end
      acx_pkg::OP_DA: begin
        res_d.acc   = da_hi[7:0]; // RULE8
        res_d.cy    = da_cy | da_hi[8]; // RULE7
        res_d.cy_we = 1'b1;
      end
      acx_pkg::OP_DEC: begin
        if (i_req.loc == acx_pkg::LOC_ACC) begin
          res_d.acc = dec8(i_acc); // RULE9
        end else begin
          res_d.data    = dec8(old_v); // RULE9
          res_d.data_we = 1'b1;
        end
      end
      acx_pkg::OP_DECREMENT_BRANCH_NONZERO_OP: begin
        // Only working register or direct byte reach here
        res_d.data    = dec8(old_v); // RULE12 RULE14
        res_d.data_we = 1'b1;
        res_d.branch  = (dec8(old_v) != acx_pkg::BYTE_ZERO); // RULE12
        res_d.target  = rel_tgt(i_req.pc_next, i_req.rel); // RULE13
      end
      acx_pkg::OP_COMPARE_BRANCH_UNEQUAL_OP: begin
        res_d.cy     = old_v < i_req.compare; // RULE15
        res_d.cy_we  = 1'b1;
        res_d.branch = old_v != i_req.compare; // RULE15
        res_d.target = rel_tgt(i_req.pc_next, i_req.rel); // RULE15
      end
      acx_pkg::OP_DIV: begin
        res_d.cy_we = 1'b1;
        res_d.ov_we = 1'b1;
        res_d.cy    = 1'b0; // RULE10 RULE11
        if (i_breg == acx_pkg::BYTE_ZERO) begin
          res_d.ov = 1'b1; // RULE11
        end else begin
          res_d.acc  = i_acc / i_breg; // RULE10
          res_d.breg = i_acc % i_breg; // RULE10
        end
      end
      default: begin
        res_d.acc = i_acc;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencing

  // Multi-cycle ops hold busy so the decoder waits; result shown from the cycle after issue
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      busy_q <= 1'b0;
      cnt_q  <= 4'h0;
      req_q  <= '0;
    end else if (i_start && !busy_q) begin
      req_q <= i_req;
      if (i_req.op == acx_pkg::OP_DIV) begin
        busy_q <= 1'b1;
        cnt_q  <= acx_pkg::CYC_DIV - 4'h1; // RULE10
      end else if (i_req.op == acx_pkg::OP_DECREMENT_BRANCH_NONZERO_OP) begin
        busy_q <= 1'b1;
        cnt_q  <= acx_pkg::CYC_DECREMENT_BRANCH_NONZERO_OP - 4'h1; // RULE16
      end else if (i_req.op == acx_pkg::OP_COMPARE_BRANCH_UNEQUAL_OP) begin
        busy_q <= 1'b1;
        cnt_q  <= acx_pkg::CYC_COMPARE_BRANCH_UNEQUAL_OP - 4'h1; // RULE15
      end else begin
        busy_q <= 1'b0;
      end
    end else if (busy_q) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == acx_pkg::CYC_ONE) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Result register, loaded at issue
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      res_q <= '0;
    end else if (i_start && !busy_q) begin
      res_q <= res_d;
    end
  end

  // Done pulses when the last cycle of the op ends
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (i_start && !busy_q && i_req.op != acx_pkg::OP_DIV && i_req.op != acx_pkg::OP_DECREMENT_BRANCH_NONZERO_OP
                 && i_req.op != acx_pkg::OP_COMPARE_BRANCH_UNEQUAL_OP && i_req.op != acx_pkg::OP_NONE)
                || (busy_q && cnt_q == acx_pkg::CYC_ONE);
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_res  = res_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_div_issue;
    i_start && !busy_q && i_req.op == acx_pkg::OP_DIV;
  endsequence

  chk_div_four_cycles: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE10
    s_div_issue |=> busy_q [*3] ##1 (!busy_q && done_q))
    else $error("divide not done after four cycles");

  chk_div_zero_ov: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE11
    s_div_issue and (i_breg == 8'h00) |=> (o_res.ov && !o_res.cy))
    else $error("divide by zero flags wrong");

  chk_clr_acc_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE1
    (i_start && !busy_q && i_req.op == acx_pkg::OP_CLR_ACC) |=> (o_res.acc == 8'h00 && done_q && !o_res.cy_we))
    else $error("clear accumulator wrong");

  chk_inv_acc: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE3
    (i_start && !busy_q && i_req.op == acx_pkg::OP_INV_ACC) |=> (o_res.acc == ~$past(i_acc)))
    else $error("complement accumulator wrong");

  chk_dec_wrap: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE9
    (i_start && !busy_q && i_req.op == acx_pkg::OP_DEC && i_req.loc == acx_pkg::LOC_ACC)
    |=> (o_res.acc == $past(i_acc) - 8'h01 && !o_res.cy_we && !o_res.ov_we))
    else $error("decrement wrong");

  chk_da_carry_kept: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE7
    (i_start && !busy_q && i_req.op == acx_pkg::OP_DA && i_cy) |=> o_res.cy)
    else $error("decimal adjust cleared carry");

  chk_decrement_branch_nonzero_op_two_cycles: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE16
    (i_start && !busy_q && i_req.op == acx_pkg::OP_DECREMENT_BRANCH_NONZERO_OP) |=> busy_q ##1 (!busy_q && done_q))
    else $error("decrement-branch timing wrong");

  chk_decrement_branch_nonzero_op_branch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE12
    (i_start && !busy_q && i_req.op == acx_pkg::OP_DECREMENT_BRANCH_NONZERO_OP)
    |=> (o_res.branch == (o_res.data != 8'h00) && !o_res.cy_we))
    else $error("decrement-branch decision wrong");

  chk_compare_branch_unequal_op_carry: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE15
    (i_start && !busy_q && i_req.op == acx_pkg::OP_COMPARE_BRANCH_UNEQUAL_OP && i_req.loc == acx_pkg::LOC_DIRECT)
    |=> (o_res.cy == ($past(i_req.operand) < $past(i_req.compare))))
    else $error("compare carry wrong");

endmodule : acx_alu

// ===== bench/tb_acx_alu.sv
`timescale 1ns/1ps
module tb_acx_alu;
  logic              i_sys_clk    = 1'b0;
  logic              i_rst_n      = 1'b0;
  logic              i_start      = 1'b0;
  acx_pkg::acx_req_s i_req        = '0;
  logic [7:0]        i_acc        = 8'h00;
  logic [7:0]        i_breg       = 8'h00;
  logic              i_cy         = 1'b0;
  logic              i_ac         = 1'b0;
  logic [7:0]        i_port_latch = 8'h00;
  logic              o_busy;
  logic              o_done;
  acx_pkg::acx_res_s o_res;
  int                fail_count   = 0;
  int                n_tests      = 0;
  int                lat;

  // 125 MHz clock
  always #4 i_sys_clk = ~i_sys_clk;

  acx_alu acx_alu_inst (
    .i_sys_clk    (i_sys_clk),
    .i_rst_n      (i_rst_n),
    .i_start      (i_start),
    .i_req        (i_req),
    .i_acc        (i_acc),
    .i_breg       (i_breg),
    .i_cy         (i_cy),
    .i_ac         (i_ac),
    .i_port_latch (i_port_latch),
    .o_busy       (o_busy),
    .o_done       (o_done),
    .o_res        (o_res)
  );

  ////////////////////////////////////////////////////////////////
  // Verdict and comparison
  task automatic stop_test();
    if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One request from a falling edge; lat counts edges up to done.
  // Bounded so a missing done cannot hang the run.
  task automatic run(input acx_pkg::acx_op_e op, input acx_pkg::acx_loc_e loc);
    int k;
    i_req.op = op;
    i_req.loc = loc;
    i_start = 1'b1;
    @(negedge i_sys_clk);
    i_start = 1'b0;
    for (k = 0; k < 8 && o_done !== 1'b1; k++) @(negedge i_sys_clk);
    if (k == 8) begin
      fail_count++;
      stop_test();
    end
    lat = k + 1;
  endtask : run

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_acc();
    i_acc = 8'h5c;
    run(acx_pkg::OP_CLR_ACC, acx_pkg::LOC_ACC);
    chk("clr_acc", {o_res.acc, o_res.cy_we, o_res.ov_we, lat[3:0]}, 14'h0001);
    run(acx_pkg::OP_INV_ACC, acx_pkg::LOC_ACC);
    chk("inv_acc", {o_res.acc, o_res.cy_we, o_res.ov_we, lat[3:0]}, {8'ha3, 6'h01});
  endtask : t_acc

  // Operand differs from the latch so a pin-side read shows up
  task automatic t_bits();
    i_cy = 1'b1;
    run(acx_pkg::OP_CLR_BIT, acx_pkg::LOC_CARRY);
    chk("clr_cy", {o_res.cy_we, o_res.cy, o_res.ov_we, lat[1:0]}, 5'b10001);
    i_cy = 1'b0;
    run(acx_pkg::OP_INV_BIT, acx_pkg::LOC_CARRY);
    chk("inv_cy", {o_res.cy_we, o_res.cy, o_res.ov_we, lat[1:0]}, 5'b11001);
    i_port_latch = 8'h5d;
    i_req.operand = 8'hff;
    i_req.bit_sel = 3'h2;
    run(acx_pkg::OP_CLR_BIT, acx_pkg::LOC_PORT);
    chk("clr_port", {o_res.data_we, o_res.data, o_res.cy_we, o_res.ov_we}, 11'h564);
    i_req.bit_sel = 3'h1;
    run(acx_pkg::OP_INV_BIT, acx_pkg::LOC_PORT);
    chk("inv_port", {o_res.data_we, o_res.data, o_res.cy_we}, 10'h2be);
    i_req.operand = 8'ha5;
    i_req.bit_sel = 3'h0;
    run(acx_pkg::OP_CLR_BIT, acx_pkg::LOC_DIRECT);
    chk("clr_dir", {o_res.data_we, o_res.data}, 9'h1a4);
  endtask : t_bits

  // Rows: acc, aux carry, carry, expected acc, expected carry
  task automatic t_da();
    logic [18:0] t [7];
    t = '{{8'hbe, 2'b00, 8'h24, 1'b1}, {8'hc9, 2'b00, 8'h29, 1'b1}, {8'h9a, 2'b00, 8'h00, 1'b1},
          {8'h15, 2'b10, 8'h1b, 1'b0}, {8'h12, 2'b01, 8'h72, 1'b1}, {8'h56, 2'b00, 8'h56, 1'b0},
          {8'hfa, 2'b00, 8'h60, 1'b1}};
    foreach (t[i]) begin
      {i_acc, i_ac, i_cy} = t[i][18:9];
      run(acx_pkg::OP_DA, acx_pkg::LOC_ACC);
      chk("da_acc", {o_res.acc, o_res.cy}, t[i][8:0]);
      chk("da_ov_lat", {o_res.ov_we, lat[3:0]}, 5'h01);
    end
    i_ac = 1'b0;
  endtask : t_da

  task automatic t_dec();
    for (int i = 0; i < 4; i++) begin
      i_acc = 8'h00;
      i_req.operand = 8'h00;
      run(acx_pkg::OP_DEC, acx_pkg::acx_loc_e'(i));
      chk("dec_val", (i == 0) ? o_res.acc : o_res.data, 8'hff);
      chk("dec_fl", {o_res.cy_we, o_res.ov_we, lat[1:0]}, 4'h1);
    end
    i_port_latch = 8'h40;
    i_req.operand = 8'h99;
    run(acx_pkg::OP_DEC, acx_pkg::LOC_PORT);
    chk("dec_port", o_res.data, 8'h3f);
  endtask : t_dec

  // Carry set beforehand so a missing clear shows
  task automatic t_div();
    i_acc = 8'hfb;
    i_breg = 8'h12;
    i_cy = 1'b1;
    run(acx_pkg::OP_DIV, acx_pkg::LOC_ACC);
    chk("div_qr", {o_res.acc, o_res.breg}, 16'h0d11);
    chk("div_fl", {o_res.cy, o_res.ov, lat[3:0]}, 6'h04);
    chk("div_busy", o_busy, 1'b0);
    i_breg = 8'h00;
    run(acx_pkg::OP_DIV, acx_pkg::LOC_ACC);
    chk("div_zero", {o_res.cy, o_res.ov}, 2'b01);
  endtask : t_div

  task automatic t_decrement_branch_nonzero_op();
    i_req.pc_next = 16'h1000;
    i_req.rel = 8'hf0;
    i_req.operand = 8'h00;
    run(acx_pkg::OP_DECREMENT_BRANCH_NONZERO_OP, acx_pkg::LOC_WREG);
    chk("decrement_branch_nonzero_op_wrap", {o_res.data, o_res.branch, o_res.target}, {8'hff, 1'b1, 16'h0ff0});
    chk("decrement_branch_nonzero_op_fl", {o_res.cy_we, o_res.ov_we, lat[3:0]}, 6'h02);
    i_req.operand = 8'h01;
    run(acx_pkg::OP_DECREMENT_BRANCH_NONZERO_OP, acx_pkg::LOC_DIRECT);
    chk("decrement_branch_nonzero_op_zero", {o_res.data, o_res.branch}, 9'h000);
  endtask : t_decrement_branch_nonzero_op

  // Rows: first, second, displacement, carry, branch, target
  task automatic t_compare_branch_unequal_op();
    logic [41:0] t [3];
    t = '{{8'h34, 8'h56, 8'h10, 2'b11, 16'h2013}, {8'h60, 8'h56, 8'hfe, 2'b01, 16'h2001},
          {8'h34, 8'h34, 8'h10, 2'b00, 16'h0000}};
    i_req.pc_next = 16'h2003;
    foreach (t[i]) begin
      {i_req.operand, i_req.compare, i_req.rel} = t[i][41:18];
      run(acx_pkg::OP_COMPARE_BRANCH_UNEQUAL_OP, acx_pkg::LOC_DIRECT);
      chk("compare_branch_unequal_op_fl", {o_res.cy_we, o_res.cy, o_res.branch, o_res.data_we, lat[1:0]}, {1'b1, t[i][17:16], 3'b010});
      if (t[i][16]) chk("compare_branch_unequal_op_tgt", o_res.target, t[i][15:0]);
    end
  endtask : t_compare_branch_unequal_op

  ////////////////////////////////////////////////////////////////
  // Reset for four cycles, then the scenarios
  initial begin
    repeat (4) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    t_acc();
    t_bits();
    t_da();
    t_dec();
    t_div();
    t_decrement_branch_nonzero_op();
    t_compare_branch_unequal_op();
    stop_test();
  end
endmodule : tb_acx_alu
